//--- rtl/ledfm_map.svh
// constants for the led fault manager
`ifndef LEDFM_MAP_SVH
`define LEDFM_MAP_SVH
`define LEDFM_DIS_PERIODS     32768
`define LEDFM_BLANK_DEF       1024
`define LEDFM_OPEN_TO_DEF     4096
`define LEDFM_CNT_W           16
`define LEDFM_REL_W           2
`define LEDFM_ADDR_CTRL       12'h000
`define LEDFM_ADDR_STAT       12'h004
`define LEDFM_ADDR_IRQ_ST     12'h008
`define LEDFM_ADDR_IRQ_MASK   12'h00C
`define LEDFM_CTRL_RST        32'h0000_0000
`define LEDFM_MASK_RST        32'h0000_0000
`define LEDFM_EV_W            7
`define LEDFM_EV_UV           0
`define LEDFM_EV_UC           1
`define LEDFM_EV_OT           2
`define LEDFM_EV_OPEN         3
`define LEDFM_EV_SHLED        4
`define LEDFM_EV_SHORT        5
`define LEDFM_EV_SLEEP        6
`endif

//--- rtl/ledfm_pkg.sv
// types of the led fault manager
package ledfm_pkg;
  typedef struct packed {
    logic uv;
    logic uc;
    logic ot;
    logic open;
    logic sh_ref;
    logic sh_nonref;
    logic short_str;
  } ledfm_cmp_t;
  typedef enum logic [1:0] {
    LEDFM_BLANK,
    LEDFM_RUN,
    LEDFM_OPEN_HOLD
  } ledfm_st_t;
endpackage : ledfm_pkg

//--- rtl/ledfm_sync.sv
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ns
module ledfm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ledfm_sync

//--- rtl/ledfm_top.sv
// led driver fault supervision with apb status and interrupt registers
`timescale 1ns/1ns
`include "ledfm_map.svh"
module ledfm_top
  import ledfm_pkg::*;
#(
  parameter int DIS_CYCLES  = `LEDFM_DIS_PERIODS,
  parameter int BLANK_CYC   = `LEDFM_BLANK_DEF,
  parameter int OPEN_TO_CYC = `LEDFM_OPEN_TO_DEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator results and pins
  input  wire ledfm_cmp_t  cmp_in,
  input  wire logic        enable_in,
  input  wire logic        primary_fault_flag_i,
  // fault flags, open drain
  output logic             primary_fault_flag_o,
  output logic             primary_fault_flag_oe,
  output logic             secondary_fault_flag_o,
  output logic             secondary_fault_flag_oe,
  // gate drive and status
  output logic             gate_drive_out,
  output logic             sleep_out,
  output logic             irq
);
  if (DIS_CYCLES < 2 || DIS_CYCLES >= (1 << `LEDFM_CNT_W) + 1 ||
      BLANK_CYC < 1 || BLANK_CYC >= (1 << `LEDFM_CNT_W) ||
      OPEN_TO_CYC < 1 || OPEN_TO_CYC >= (1 << `LEDFM_CNT_W))
  begin : g_bad_count
    $error("ledfm_top: count parameter out of range");
  end

  localparam logic [`LEDFM_CNT_W-1:0] DIS_LAST =
    `LEDFM_CNT_W'(DIS_CYCLES - 1);
  localparam logic [`LEDFM_CNT_W-1:0] BLANK_LAST =
    `LEDFM_CNT_W'(BLANK_CYC - 1);
  localparam logic [`LEDFM_CNT_W-1:0] OPEN_LAST =
    `LEDFM_CNT_W'(OPEN_TO_CYC - 1);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [8:0] raw_in;
  logic [8:0] syn_in;
  assign raw_in = {cmp_in, enable_in, primary_fault_flag_i};
  ledfm_sync #(.W(9)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw_in),
    .q       (syn_in)
  );
  ledfm_cmp_t cmp_s;
  logic       en_s;
  logic       ff1_ext_low;
  assign cmp_s       = ledfm_cmp_t'(syn_in[8:2]);
  assign en_s        = syn_in[1];
  assign ff1_ext_low = !syn_in[0];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ledfm_st_t                 st;
    logic [`LEDFM_CNT_W-1:0]   cnt;
    logic [`LEDFM_CNT_W-1:0]   dis_cnt;
    logic                      sleep;
    logic                      short_lat;
    logic                      ff1_rel;
    logic                      ff2_rel;
    logic                      ff2_drv;
    logic [`LEDFM_REL_W-1:0]   rel_age;
    logic                      gate;
    logic                      ff1_drv;
    logic [`LEDFM_EV_W-1:0]    stat;
    logic [`LEDFM_EV_W-1:0]    irq_st;
    logic [`LEDFM_EV_W-1:0]    mask;
    logic                      gate_req;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      irq;
  } ledfm_state_t;

  ledfm_state_t s_r;
  ledfm_state_t s_nxt;

  function automatic logic [31:0] ledfm_zext(
    input logic [`LEDFM_EV_W-1:0] v
  );
    ledfm_zext = {{(32 - `LEDFM_EV_W){1'b0}}, v};
  endfunction : ledfm_zext

  logic                   active;
  logic                   sh_led;
  logic                   monitor;
  logic [`LEDFM_EV_W-1:0] ev;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   ff2_rel_c;
  logic                   ff1_ovr;

  always_comb
  begin
    s_nxt   = s_r;
    active  = !s_r.sleep && en_s;
    monitor = (s_r.st != LEDFM_BLANK);
    sh_led  = monitor && (cmp_s.sh_ref || cmp_s.sh_nonref);
    wr_acc  = psel && penable && pwrite && s_r.pready;
    rd_acc  = psel && penable && !pwrite && !s_r.pready;
    ff1_ovr = ff1_ext_low && (s_r.rel_age == '1);

    // enable low timing: sleep after the disable time
    if (en_s)
    begin
      s_nxt.dis_cnt = '0;
      s_nxt.sleep   = 1'b0;
    end
    else if (s_r.dis_cnt == DIS_LAST)
    begin
      s_nxt.sleep     = 1'b1;
      s_nxt.short_lat = 1'b0;
    end
    else
      s_nxt.dis_cnt = s_r.dis_cnt + `LEDFM_CNT_W'(1);

    // sequencer
    unique case (s_r.st)
      LEDFM_BLANK:
      begin
        if (!active || cmp_s.uv)
          s_nxt.cnt = '0;
        else if (s_r.cnt == BLANK_LAST)
        begin
          s_nxt.st  = LEDFM_RUN;
          s_nxt.cnt = '0;
        end
        else
          s_nxt.cnt = s_r.cnt + `LEDFM_CNT_W'(1);
        if (active && cmp_s.open && !cmp_s.uv)
        begin
          s_nxt.st  = LEDFM_OPEN_HOLD;
          s_nxt.cnt = '0;
        end
      end
      LEDFM_RUN:
      begin
        if (s_r.sleep || cmp_s.uv)
        begin
          s_nxt.st  = LEDFM_BLANK;
          s_nxt.cnt = '0;
        end
        else if (active && cmp_s.open)
        begin
          s_nxt.st  = LEDFM_OPEN_HOLD;
          s_nxt.cnt = '0;
        end
        if (active && cmp_s.short_str && !cmp_s.uv)
          s_nxt.short_lat = 1'b1;
      end
      LEDFM_OPEN_HOLD:
      begin
        if (s_r.sleep || cmp_s.uv)
        begin
          s_nxt.st  = LEDFM_BLANK;
          s_nxt.cnt = '0;
        end
        else if (s_r.cnt == OPEN_LAST)
        begin
          s_nxt.st  = LEDFM_RUN;
          s_nxt.cnt = '0;
        end
        else
          s_nxt.cnt = s_r.cnt + `LEDFM_CNT_W'(1);
      end
    endcase

    // own pull-down must fade from the sensed wire before override counts
    if (s_r.ff1_drv)
      s_nxt.rel_age = '0;
    else if (s_r.rel_age != '1)
      s_nxt.rel_age = s_r.rel_age + `LEDFM_REL_W'(1);

    // flag and gate decode
    s_nxt.ff1_rel = cmp_s.uv || s_r.short_lat;
    ff2_rel_c     = cmp_s.uv || (s_r.st == LEDFM_OPEN_HOLD)
                  || (monitor && cmp_s.uc)
                  || (monitor && cmp_s.ot)
                  || sh_led;
    s_nxt.ff2_rel = ff2_rel_c;
    s_nxt.ff2_drv = !ff2_rel_c;
    s_nxt.gate_req = active && !cmp_s.uv
                  && (s_r.st != LEDFM_OPEN_HOLD)
                  && (!s_r.short_lat || ff1_ovr);
    s_nxt.gate    = s_r.gate_req;
    s_nxt.ff1_drv = !s_r.ff1_rel;
    s_nxt.stat    = {s_r.sleep, s_r.short_lat, sh_led,
                     s_r.st == LEDFM_OPEN_HOLD, monitor && cmp_s.ot,
                     monitor && cmp_s.uc, cmp_s.uv};

    // sticky events, set wins over write-one clear
    ev = s_r.stat;
    if (wr_acc && paddr == `LEDFM_ADDR_IRQ_ST)
      s_nxt.irq_st = (s_r.irq_st & ~pwdata[`LEDFM_EV_W-1:0]) | ev;
    else
      s_nxt.irq_st = s_r.irq_st | ev;
    if (wr_acc && paddr == `LEDFM_ADDR_IRQ_MASK)
      s_nxt.mask = pwdata[`LEDFM_EV_W-1:0];
    s_nxt.irq = |(s_r.irq_st & s_r.mask);

    // apb answer one cycle after the access phase starts
    s_nxt.pready  = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = '0;
    if (rd_acc)
    begin
      unique case (paddr)
        `LEDFM_ADDR_CTRL:     s_nxt.prdata = ledfm_zext(s_r.mask);
        `LEDFM_ADDR_STAT:     s_nxt.prdata = ledfm_zext(s_r.stat);
        `LEDFM_ADDR_IRQ_ST:   s_nxt.prdata = ledfm_zext(s_r.irq_st);
        `LEDFM_ADDR_IRQ_MASK: s_nxt.prdata = ledfm_zext(s_r.mask);
        default:              s_nxt.pslverr = 1'b1;
      endcase
    end
    // the error comes with pready; a write lands at the pready edge
    if (psel && penable && pwrite && !s_r.pready
        && paddr != `LEDFM_ADDR_IRQ_ST
        && paddr != `LEDFM_ADDR_IRQ_MASK)
      s_nxt.pslverr = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r         <= '0;
      s_r.st      <= LEDFM_BLANK;
      s_r.ff1_rel <= 1'b1;
      s_r.ff2_rel <= 1'b1;
      s_r.mask    <= `LEDFM_EV_W'(`LEDFM_MASK_RST);
    end
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign primary_fault_flag_o    = 1'b0;
  assign primary_fault_flag_oe   = s_r.ff1_drv;
  assign secondary_fault_flag_o  = 1'b0;
  assign secondary_fault_flag_oe = s_r.ff2_drv;
  assign gate_drive_out          = s_r.gate;
  assign sleep_out               = s_r.sleep;
  assign irq                     = s_r.irq;
  assign prdata                  = s_r.prdata;
  assign pready                  = s_r.pready;
  assign pslverr                 = s_r.pslverr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_uv_gate_off: assert property (
    cmp_s.uv |-> ##2 !gate_drive_out)
    else $error("gate not off after undervoltage");
  chk_uv_flags: assert property (
    cmp_s.uv |-> ##1 !secondary_fault_flag_oe ##1 !primary_fault_flag_oe)
    else $error("flags not released after undervoltage");
  chk_open_gate: assert property (
    s_r.st == LEDFM_OPEN_HOLD |-> ##2 !gate_drive_out)
    else $error("gate on during open hold");
  chk_open_flag: assert property (
    s_r.st == LEDFM_OPEN_HOLD |-> ##1 !secondary_fault_flag_oe)
    else $error("secondary not released in open hold");
  chk_short_latch: assert property (
    s_r.short_lat && en_s |=> s_r.short_lat)
    else $error("short latch lost while enabled");
  chk_short_ff1: assert property (
    s_r.short_lat |-> ##2 !primary_fault_flag_oe)
    else $error("primary not released on short");
  chk_blank_quiet: assert property (
    s_r.st == LEDFM_BLANK && !cmp_s.uv |->
      ##1 (s_r.ff2_rel == 1'b0 || $past(cmp_s.uv)))
    else $error("fault flagged during blanking");
  chk_sleep_entry: assert property (
    $rose(s_r.sleep) |-> !s_r.short_lat && !$past(en_s))
    else $error("sleep without clearing latch");
  chk_override: assert property (
    s_r.short_lat && ff1_ext_low && s_r.rel_age == '1 && active
      && !cmp_s.uv && s_r.st != LEDFM_OPEN_HOLD |-> ##2 gate_drive_out)
    else $error("external override ignored");
  chk_uc_flag: assert property (
    monitor && cmp_s.uc |-> ##1 !secondary_fault_flag_oe)
    else $error("secondary not released on undercurrent");
  chk_ot_flag: assert property (
    monitor && cmp_s.ot |-> ##1 !secondary_fault_flag_oe)
    else $error("secondary not released on overtemperature");
  chk_shled_flag: assert property (
    sh_led |-> ##1 !secondary_fault_flag_oe)
    else $error("secondary not released on shorted led");
  chk_open_unblank: assert property (
    s_r.st == LEDFM_BLANK && active && cmp_s.open && !cmp_s.uv
      |=> s_r.st == LEDFM_OPEN_HOLD)
    else $error("open led blanked");
  chk_short_gate: assert property (
    s_r.short_lat && !ff1_ext_low |-> ##2 !gate_drive_out)
    else $error("gate on with short latched");
  chk_self_pull: assert property (
    s_r.short_lat && s_r.rel_age != '1 |-> ##2 !gate_drive_out)
    else $error("own pull-down taken as override");
  chk_sleep_gate: assert property (
    s_r.sleep |-> ##2 !gate_drive_out)
    else $error("gate on in sleep");

  cov_open: cover property (s_r.st == LEDFM_OPEN_HOLD ##1
                            s_r.st == LEDFM_RUN);
  cov_short: cover property ($rose(s_r.short_lat));
  cov_sleep: cover property ($rose(s_r.sleep));
  cov_irq:   cover property ($rose(irq));
endmodule : ledfm_top

//--- testbench/ledfm_flag_model.sv
// pull-ups on the two open-drain fault flag wires, system monitor on the primary wire
`timescale 1ns/1ns
module ledfm_flag_model (
  // drivers of the wires
  input  wire logic primary_oe,
  input  wire logic secondary_oe,
  input  wire logic hold_primary_low,
  // resolved wire levels
  output logic      primary_wire,
  output logic      secondary_wire
);
  // released wire floats to the pull-up level
  assign secondary_wire = !secondary_oe;
  // monitor may hold the primary wire low to keep the output running
  assign primary_wire = !(primary_oe || hold_primary_low);
endmodule : ledfm_flag_model

//--- testbench/tb_top.sv
// self-checking bench for the led fault manager
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import ledfm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, enable_in, hold_low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, p_oe, s_oe, gate, sleep, irq;
  logic        p_wire, s_wire, p_o, s_o;
  ledfm_cmp_t  cmp;
  int          bad_count, comparisons;
  ledfm_top #(.DIS_CYCLES(16), .BLANK_CYC(20), .OPEN_TO_CYC(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp),
    .enable_in(enable_in), .primary_fault_flag_i(p_wire),
    .primary_fault_flag_o(p_o), .primary_fault_flag_oe(p_oe),
    .secondary_fault_flag_o(s_o), .secondary_fault_flag_oe(s_oe),
    .gate_drive_out(gate), .sleep_out(sleep), .irq(irq));
  ledfm_flag_model u_flags (.primary_oe(p_oe), .secondary_oe(s_oe),
    .hold_primary_low(hold_low), .primary_wire(p_wire),
    .secondary_wire(s_wire));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_blank();
    cmp <= 7'h20;
    cyc(10);
    `CHK(s_oe, 1'b1)
    cyc(30);
    `CHK(s_oe, 1'b0)
    cmp <= 7'h00;
    cyc(10);
    `CHK({p_oe, s_oe, gate}, 3'h7)
    `CHK({p_o, s_o}, 2'h0)
  endtask : t_blank
  task automatic t_warn();
    int ks[4];
    ks = '{5, 4, 2, 1};
    foreach (ks[i])
    begin
      cmp <= 7'h01 << ks[i];
      cyc(8);
      `CHK({p_oe, s_oe, gate, s_wire}, 4'hB)
      cmp <= 7'h00;
      cyc(8);
      `CHK(s_oe, 1'b1)
    end
  endtask : t_warn
  task automatic t_uv();
    cmp <= 7'h40;
    cyc(8);
    `CHK({p_oe, s_oe, gate}, 3'h0)
    cmp <= 7'h08;
    cyc(6);
    `CHK({s_oe, gate}, 2'h0)
    cmp <= 7'h00;
    cyc(40);
    `CHK(gate, 1'b1)
  endtask : t_uv
  task automatic t_open();
    int hi;
    hi = 0;
    cmp <= 7'h08;
    cyc(8);
    `CHK({s_oe, gate}, 2'h0)
    repeat (40)
    begin
      @(posedge pclk);
      hi += gate;
    end
    `CHK(hi > 0 && hi < 40, 1'b1)
    cmp <= 7'h00;
    cyc(20);
    `CHK({s_oe, gate}, 2'h3)
  endtask : t_open
  task automatic t_short();
    cmp <= 7'h01;
    cyc(8);
    `CHK({p_oe, s_oe, gate}, 3'h2)
    cmp <= 7'h00;
    cyc(10);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK({p_oe, rd[5]}, 2'h1)
    hold_low <= 1'b1;
    cyc(8);
    `CHK(gate, 1'b1)
    hold_low <= 1'b0;
    cyc(8);
    `CHK(gate, 1'b0)
    enable_in <= 1'b0;
    cyc(6);
    enable_in <= 1'b1;
    cyc(12);
    `CHK({p_oe, sleep}, 2'h0)
    enable_in <= 1'b0;
    cyc(30);
    `CHK(sleep, 1'b1)
    enable_in <= 1'b1;
    cyc(40);
    `CHK({p_oe, gate, sleep}, 3'h6)
  endtask : t_short
  task automatic t_apb();
    apb(1'b0, 12'h00C, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, 12'h004, 32'h0000_007F);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h00C, 32'h0000_007F);
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK(rd, 32'h0000_007F)
    cyc(3);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h008, 32'h0000_007F);
    cyc(3);
    `CHK(irq, 1'b0)
    cmp <= 7'h20;
    cyc(10);
    `CHK(irq, 1'b1)
    cmp <= 7'h00;
  endtask : t_apb
  task automatic t_power();
    cmp <= 7'h01;
    cyc(8);
    `CHK(p_oe, 1'b0)
    cmp <= 7'h00;
    cyc(4);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(10);
    `CHK({p_oe, gate, sleep}, 3'h6)
  endtask : t_power
  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, hold_low} = 5'h00;
    {paddr, pwdata, cmp} = '0;
    enable_in = 1'b1;
    cyc(5);
    presetn <= 1'b1;
    t_blank();
    t_warn();
    t_uv();
    t_open();
    t_short();
    t_apb();
    t_power();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top
